//--- include/atscr_pkg.sv
// Functional notes
// - Write D1h to port 64h then 02h to port 60h raises the A20 gate.
// - Write FEh to port 64h starts a fast warm reset, per qualification setting.
// - After D0h to port 64h, port 60h reads A20 in bit 1, reset in bit 0.
// - Port 61h bit 7 parity flag sets only while bit 2 low; writing 1 to bit 2 clears.
// - Port 61h bit 6 channel flag sets only while bit 3 low; writing 1 to bit 3 clears.
// - Port 61h bit 5 reads the live timer 2 output level.
// - Port 61h bit 4 toggles once per refresh cycle.
// - Bit 3 low lets a low channel-error input raise NMI; high ignores it.
// - Bit 2 low lets memory parity errors raise NMI; high blocks them.
// - Bit 1 gates timer 2 output onto the speaker; low holds speaker low.
// - Bit 0 drives the timer 2 gate input.
// - Revision_bus_config bits 5:4 pick 3, 4, 5 or 6 bus clocks I/O recovery.
// - Revision_bus_config bits 1:0 pick bus clock as double clock over 10, 8, 6, 4.
// - System_control_config bit 7 enables bus master byte swap, reset off.
// - System_control_config bit 6 picks single or per-cycle address latch pulses, reset 1.
// - System_control_config bit 5 low waits for halt after FEh; high resets directly.
// - System_control_config bit 4 adds one wait state to standard bus cycles.
// - System_control_config bit 0 low enables parity checking, high disables it.
// - Index written at port 22h before each port 24h access; index then clears.
package atscr_pkg;
    localparam logic [7:0] PORT_KBD_DATA     = 8'h60;
    localparam logic [7:0] PORT_KBD_CMD      = 8'h64;
    localparam logic [7:0] PORT_SYS_STATUS   = 8'h61;
    localparam logic [7:0] PORT_CFG_INDEX    = 8'h22;
    localparam logic [7:0] PORT_CFG_DATA     = 8'h24;
    localparam logic [7:0] IDX_REV_BUS_CFG   = 8'h20;
    localparam logic [7:0] IDX_SYS_CTRL_CFG  = 8'h21;

    localparam logic [7:0] CMD_WRITE_OUTPUT  = 8'hD1;
    localparam logic [7:0] CMD_READ_STATUS   = 8'hD0;
    localparam logic [7:0] CMD_FAST_RESET    = 8'hFE;
    localparam logic [7:0] DATA_A20_ON       = 8'h02;

    // Port 61h fields
    localparam int SST_PARITY_FLAG = 7;
    localparam int SST_CHANNEL_FLAG = 6;
    localparam int SST_TIMER2_OUT  = 5;
    localparam int SST_REFRESH_TGL = 4;
    localparam int SST_CHANNEL_DIS = 3;
    localparam int SST_PARITY_DIS  = 2;
    localparam int SST_SPEAKER_EN  = 1;
    localparam int SST_TIMER2_GATE = 0;
    localparam logic [3:0] SST_CTRL_RESET = 4'h0;

    // Revision_bus_config fields
    localparam int RBC_REV_MSB     = 7;
    localparam int RBC_REV_LSB     = 6;
    localparam int RBC_RECOV_MSB   = 5;
    localparam int RBC_RECOV_LSB   = 4;
    localparam int RBC_SLOW_REF    = 3;
    localparam int RBC_HIDDEN_REF  = 2;
    localparam int RBC_CLKSEL_MSB  = 1;
    localparam int RBC_CLKSEL_LSB  = 0;
    localparam logic [5:0] RBC_RW_RESET = 6'h00;
    // Revision code: value is arbitrary
    localparam logic [1:0] RBC_REVISION = 2'h1;

    // System_control_config fields
    localparam int SCC_BYTE_SWAP   = 7;
    localparam int SCC_ALE_MULTI   = 6;
    localparam int SCC_RESET_DIRECT = 5;
    localparam int SCC_EXTRA_WAIT  = 4;
    localparam int SCC_PARITY_DIS  = 0;
    localparam logic [7:0] SCC_RESET = 8'h40;

    // Recovery base: code 00 means 3 bus clocks
    localparam logic [2:0] RECOVERY_BASE = 3'h3;
    // Half periods of the bus clock for divide by 10, 8, 6, 4
    localparam logic [2:0] HALF_DIV10 = 3'h5;
    localparam logic [2:0] HALF_DIV8  = 3'h4;
    localparam logic [2:0] HALF_DIV6  = 3'h3;
    localparam logic [2:0] HALF_DIV4  = 3'h2;

    localparam int CLK_PERIOD_PS      = 8000;
    localparam int RESET_PULSE_NS     = 1000;
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [0:0] {
        KBD_IDLE        = 1'b0,
        KBD_OUTPUT_DATA = 1'b1
    } atscr_kbd_state_type;
endpackage

//--- hdl/atscr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module atscr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stage1   <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

//--- hdl/atscr_top.sv
`timescale 1ns/1ps
`default_nettype none
module atscr_top (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    output var  logic [7:0] io_rdata,
    output var  logic       io_rd_claim,
    input  wire logic       halt_cycle,
    input  wire logic       refresh_pulse,
    input  wire logic       parity_error,
    input  wire logic       channel_error_in_n,
    input  wire logic       timer2_output,
    output var  logic       a20_line_gate,
    output var  logic       processor_reset_out,
    output var  logic       nmi_out,
    output var  logic       speaker_out,
    output var  logic       timer2_gate,
    output var  logic       expansion_bus_clock,
    output var  logic [2:0] io_recovery_clocks,
    output var  logic       slow_refresh_en,
    output var  logic       hidden_refresh_en,
    output var  logic       byte_swap_en,
    output var  logic       ale_per_cycle,
    output var  logic       extra_wait_en,
    output var  logic       parity_check_en
);
    import atscr_pkg::*;

    localparam logic [7:0] RESET_LEN = 8'(RESET_PULSE_CYCLES);

    logic channel_err_n_sync;
    logic timer2_sync;

    atscr_sync #(.WIDTH(1), .RESET_VALUE(1'b1)) u_sync_chk (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (channel_error_in_n),
        .sync_out (channel_err_n_sync)
    );

    atscr_sync #(.WIDTH(1), .RESET_VALUE(1'b0)) u_sync_t2 (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (timer2_output),
        .sync_out (timer2_sync)
    );

    atscr_kbd_state_type kbd_state;
    atscr_kbd_state_type next_kbd_state;
    logic       status_readable;
    logic       next_status_readable;
    logic       halt_armed;
    logic       next_halt_armed;
    logic [7:0] reset_count;
    logic [7:0] next_reset_count;
    logic       next_a20;
    logic [7:0] cfg_index;
    logic [7:0] next_cfg_index;
    logic       index_valid;
    logic       next_index_valid;
    logic [5:0] rev_bus_cfg;
    logic [5:0] next_rev_bus_cfg;
    logic [7:0] sys_ctrl_cfg;
    logic [7:0] next_sys_ctrl_cfg;
    logic [3:0] sst_ctrl;
    logic [3:0] next_sst_ctrl;
    logic       parity_flag;
    logic       next_parity_flag;
    logic       channel_flag;
    logic       next_channel_flag;
    logic       refresh_toggle;
    logic       next_refresh_toggle;
    logic [7:0] next_rdata;
    logic       next_rd_claim;
    logic [2:0] div_count;
    logic [2:0] next_div_count;
    logic       next_bus_clock;
    logic [2:0] half_period;

    logic wr_kbd_cmd;
    logic wr_kbd_data;
    logic wr_sst;
    logic cfg_access;
    logic reset_start;

    assign wr_kbd_cmd  = io_wr && (io_addr == PORT_KBD_CMD);
    assign wr_kbd_data = io_wr && (io_addr == PORT_KBD_DATA);
    assign wr_sst      = io_wr && (io_addr == PORT_SYS_STATUS);
    assign cfg_access  = (io_wr || io_rd) && (io_addr == PORT_CFG_DATA);

    // Keyboard controller emulation
    always_comb begin
        next_kbd_state       = kbd_state;
        next_status_readable = status_readable;
        next_halt_armed      = halt_armed;
        next_a20             = a20_line_gate;
        reset_start          = 1'b0;
        if (wr_kbd_cmd) begin
            next_kbd_state       = KBD_IDLE;
            next_status_readable = (io_wdata == CMD_READ_STATUS);
            if (io_wdata == CMD_WRITE_OUTPUT) begin
                next_kbd_state = KBD_OUTPUT_DATA;
            end
            if (io_wdata == CMD_FAST_RESET) begin
                if (sys_ctrl_cfg[SCC_RESET_DIRECT]) begin
                    reset_start = 1'b1;
                end else begin
                    next_halt_armed = 1'b1;
                end
            end
        end
        if (wr_kbd_data && (kbd_state == KBD_OUTPUT_DATA)) begin
            next_kbd_state = KBD_IDLE;
            next_a20       = (io_wdata == DATA_A20_ON);
        end
        if (halt_armed && halt_cycle) begin
            reset_start     = 1'b1;
            next_halt_armed = 1'b0;
        end
    end

    // Warm reset pulse; a restart while running stretches it
    always_comb begin
        next_reset_count = reset_count;
        if (reset_start) begin
            next_reset_count = RESET_LEN;
        end else if (reset_count != 8'h00) begin
            next_reset_count = reset_count - 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            kbd_state           <= KBD_IDLE;
            status_readable     <= 1'b0;
            halt_armed          <= 1'b0;
            a20_line_gate       <= 1'b0;
            reset_count         <= 8'h00;
            processor_reset_out <= 1'b0;
        end else begin
            kbd_state           <= next_kbd_state;
            status_readable     <= next_status_readable;
            halt_armed          <= next_halt_armed;
            a20_line_gate       <= next_a20;
            reset_count         <= next_reset_count;
            processor_reset_out <= (next_reset_count != 8'h00);
        end
    end

    // Indexed configuration and port 61h
    always_comb begin
        next_cfg_index      = cfg_index;
        next_index_valid    = index_valid;
        next_rev_bus_cfg    = rev_bus_cfg;
        next_sys_ctrl_cfg   = sys_ctrl_cfg;
        next_sst_ctrl       = sst_ctrl;
        next_parity_flag    = parity_flag;
        next_channel_flag   = channel_flag;
        next_refresh_toggle = refresh_toggle ^ refresh_pulse;
        if (io_wr && (io_addr == PORT_CFG_INDEX)) begin
            next_cfg_index   = io_wdata;
            next_index_valid = 1'b1;
        end
        if (cfg_access) begin
            // Every data access consumes the index
            next_cfg_index   = 8'h00;
            next_index_valid = 1'b0;
            if (io_wr && index_valid && (cfg_index == IDX_REV_BUS_CFG)) begin
                next_rev_bus_cfg = io_wdata[5:0];
            end
            if (io_wr && index_valid && (cfg_index == IDX_SYS_CTRL_CFG)) begin
                next_sys_ctrl_cfg = io_wdata;
            end
        end
        if (wr_sst) begin
            next_sst_ctrl = io_wdata[3:0];
            if (io_wdata[SST_PARITY_DIS]) begin
                next_parity_flag = 1'b0;
            end
            if (io_wdata[SST_CHANNEL_DIS]) begin
                next_channel_flag = 1'b0;
            end
        end
        // Set is applied last so a coincident event beats the clear
        if (parity_error && !sst_ctrl[SST_PARITY_DIS] && !sys_ctrl_cfg[SCC_PARITY_DIS]) begin
            next_parity_flag = 1'b1;
        end
        if (!channel_err_n_sync && !sst_ctrl[SST_CHANNEL_DIS]) begin
            next_channel_flag = 1'b1;
        end
    end

    // Read data, answered one cycle after the strobe
    always_comb begin
        next_rdata    = 8'h00;
        next_rd_claim = 1'b0;
        if (io_rd) begin
            unique case (io_addr)
                PORT_SYS_STATUS: begin
                    next_rd_claim = 1'b1;
                    next_rdata    = {parity_flag, channel_flag, timer2_sync,
                                     refresh_toggle, sst_ctrl};
                end
                PORT_KBD_DATA: begin
                    // Otherwise the real keyboard controller answers
                    if (status_readable) begin
                        next_rd_claim = 1'b1;
                        next_rdata    = {6'h00, a20_line_gate, processor_reset_out};
                    end
                end
                PORT_CFG_DATA: begin
                    if (index_valid && (cfg_index == IDX_REV_BUS_CFG)) begin
                        next_rd_claim = 1'b1;
                        next_rdata    = {RBC_REVISION, rev_bus_cfg};
                    end else if (index_valid && (cfg_index == IDX_SYS_CTRL_CFG)) begin
                        next_rd_claim = 1'b1;
                        next_rdata    = sys_ctrl_cfg;
                    end
                end
                default: begin
                    next_rd_claim = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_index      <= 8'h00;
            index_valid    <= 1'b0;
            rev_bus_cfg    <= RBC_RW_RESET;
            sys_ctrl_cfg   <= SCC_RESET;
            sst_ctrl       <= SST_CTRL_RESET;
            parity_flag    <= 1'b0;
            channel_flag   <= 1'b0;
            refresh_toggle <= 1'b0;
            io_rdata       <= 8'h00;
            io_rd_claim    <= 1'b0;
        end else begin
            cfg_index      <= next_cfg_index;
            index_valid    <= next_index_valid;
            rev_bus_cfg    <= next_rev_bus_cfg;
            sys_ctrl_cfg   <= next_sys_ctrl_cfg;
            sst_ctrl       <= next_sst_ctrl;
            parity_flag    <= next_parity_flag;
            channel_flag   <= next_channel_flag;
            refresh_toggle <= next_refresh_toggle;
            io_rdata       <= next_rdata;
            io_rd_claim    <= next_rd_claim;
        end
    end

    // Bus clock divider; core_clk serves as the double-rate CPU clock
    always_comb begin
        unique case (rev_bus_cfg[RBC_CLKSEL_MSB:RBC_CLKSEL_LSB])
            2'h0: half_period = HALF_DIV10;
            2'h1: half_period = HALF_DIV8;
            2'h2: half_period = HALF_DIV6;
            2'h3: half_period = HALF_DIV4;
        endcase
        next_div_count = div_count + 3'h1;
        next_bus_clock = expansion_bus_clock;
        // Compare with >= so a shorter setting never leaves the count stranded
        if ((div_count + 3'h1) >= half_period) begin
            next_div_count = 3'h0;
            next_bus_clock = !expansion_bus_clock;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_count           <= 3'h0;
            expansion_bus_clock <= 1'b0;
        end else begin
            div_count           <= next_div_count;
            expansion_bus_clock <= next_bus_clock;
        end
    end

    // Registered control outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            nmi_out            <= 1'b0;
            speaker_out        <= 1'b0;
            timer2_gate        <= 1'b0;
            io_recovery_clocks <= RECOVERY_BASE;
            slow_refresh_en    <= 1'b0;
            hidden_refresh_en  <= 1'b0;
            byte_swap_en       <= 1'b0;
            ale_per_cycle      <= 1'b1;
            extra_wait_en      <= 1'b0;
            parity_check_en    <= 1'b1;
        end else begin
            nmi_out            <= parity_flag || channel_flag;
            speaker_out        <= timer2_sync && sst_ctrl[SST_SPEAKER_EN];
            timer2_gate        <= sst_ctrl[SST_TIMER2_GATE];
            io_recovery_clocks <= RECOVERY_BASE
                                + {1'b0, rev_bus_cfg[RBC_RECOV_MSB:RBC_RECOV_LSB]};
            slow_refresh_en    <= rev_bus_cfg[RBC_SLOW_REF];
            hidden_refresh_en  <= rev_bus_cfg[RBC_HIDDEN_REF];
            byte_swap_en       <= sys_ctrl_cfg[SCC_BYTE_SWAP];
            ale_per_cycle      <= sys_ctrl_cfg[SCC_ALE_MULTI];
            extra_wait_en      <= sys_ctrl_cfg[SCC_EXTRA_WAIT];
            parity_check_en    <= !sys_ctrl_cfg[SCC_PARITY_DIS];
        end
    end
endmodule
`default_nettype wire

//--- test/atscr_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module atscr_chk (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic       io_rd_claim,
    input wire logic       halt_cycle,
    input wire logic       parity_error,
    input wire logic       channel_error_in_n,
    input wire logic       timer2_output,
    input wire logic       a20_line_gate,
    input wire logic       processor_reset_out,
    input wire logic       nmi_out,
    input wire logic       speaker_out,
    input wire logic [2:0] io_recovery_clocks
);
    import atscr_pkg::*;
    wire logic fe_wr  = io_wr && io_addr == PORT_KBD_CMD && io_wdata == CMD_FAST_RESET;
    wire logic cfg_wr = io_wr && io_addr == PORT_CFG_DATA;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_cmd_out;
        io_wr && io_addr == PORT_KBD_CMD && io_wdata == CMD_WRITE_OUTPUT;
    endsequence
    sequence s_data_on;
        io_wr && io_addr == PORT_KBD_DATA && io_wdata == DATA_A20_ON;
    endsequence
    a_a20_set: assert property (s_cmd_out ##1 !io_wr ##1 s_data_on |=> a20_line_gate)
        else $error("a20 gate not raised");
    a_reset_cause: assert property ($rose(processor_reset_out) |-> $past(fe_wr) || $past(halt_cycle))
        else $error("warm reset without cause");
    a_claim_after: assert property (io_rd_claim |-> $past(io_rd))
        else $error("claim without read");
    a_rdata_idle: assert property (!$past(io_rd) |-> io_rdata == 8'h00)
        else $error("read data outside answer");
    a_nmi_cause: assert property ($rose(nmi_out) |-> $past(parity_error, 2) || $past(parity_error, 3) || $past(!channel_error_in_n, 4) || $past(!channel_error_in_n, 5))
        else $error("nmi without cause");
    a_speaker_gate: assert property (speaker_out |-> $past(timer2_output, 3))
        else $error("speaker high without timer");
    sequence s_rbc_write;
        io_wr && io_addr == PORT_CFG_INDEX && io_wdata == IDX_REV_BUS_CFG ##1 !io_wr ##1 cfg_wr;
    endsequence
    a_recov_range: assert property (s_rbc_write |-> ##2
        io_recovery_clocks == RECOVERY_BASE + {1'b0, $past(io_wdata[5:4], 2)})
        else $error("recovery count not taken from write");
    a_recov_write: assert property ($changed(io_recovery_clocks) |-> $past(cfg_wr, 2))
        else $error("recovery changed without data access");
endmodule
bind atscr_top atscr_chk u_atscr_chk (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .io_rd_claim(io_rd_claim), .halt_cycle(halt_cycle), .parity_error(parity_error),
    .channel_error_in_n(channel_error_in_n), .timer2_output(timer2_output),
    .a20_line_gate(a20_line_gate), .processor_reset_out(processor_reset_out),
    .nmi_out(nmi_out), .speaker_out(speaker_out), .io_recovery_clocks(io_recovery_clocks));
`default_nettype wire

//--- test/atscr_host.sv
`timescale 1ns/1ps
`default_nettype none
module atscr_host (
    input  wire logic       core_clk,
    output var  logic [7:0] io_addr,
    output var  logic [7:0] io_wdata,
    output var  logic       io_wr,
    output var  logic       io_rd,
    input  wire logic [7:0] io_rdata,
    input  wire logic       io_rd_claim
);
    import atscr_pkg::*;
    initial begin
        io_addr = 8'h00;
        io_wdata = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end
    // Released lines show inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge core_clk);
        #1;
        io_addr = a;
        io_wdata = dt;
        io_wr = 1'b1;
        @(posedge core_clk);
        #1;
        io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~dt;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dt, output logic cl);
        @(posedge core_clk);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge core_clk);
        #1;
        io_rd = 1'b0;
        io_addr = ~a;
        dt = io_rdata;
        cl = io_rd_claim;
    endtask
    // Index written before every data access, never reused
    task automatic cfg_wr(input logic [7:0] i, input logic [7:0] dt);
        wr(PORT_CFG_INDEX, i);
        wr(PORT_CFG_DATA, dt);
    endtask
    task automatic cfg_rd(input logic [7:0] i, output logic [7:0] dt, output logic cl);
        wr(PORT_CFG_INDEX, i);
        rd(PORT_CFG_DATA, dt, cl);
    endtask
endmodule
`default_nettype wire

//--- test/atscr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module atscr_top_tb;
    import atscr_pkg::*;
    logic            core_clk, rstn, halt_cycle, refresh_pulse, parity_error;
    logic            channel_error_in_n, timer2_output, c;
    logic      [7:0] d;
    logic      [1:0] cd;
    wire logic [7:0] io_addr, io_wdata, io_rdata;
    wire logic [2:0] io_recovery_clocks;
    wire logic       io_wr, io_rd, io_rd_claim, a20_line_gate, processor_reset_out, nmi_out;
    wire logic       speaker_out, timer2_gate, expansion_bus_clock, slow_refresh_en;
    wire logic       hidden_refresh_en, byte_swap_en, ale_per_cycle, extra_wait_en;
    wire logic       parity_check_en;
    int              mismatches, n_tests, h, n;
    atscr_top u_atscr_top (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .io_rd_claim(io_rd_claim), .halt_cycle(halt_cycle), .refresh_pulse(refresh_pulse),
        .parity_error(parity_error), .channel_error_in_n(channel_error_in_n),
        .timer2_output(timer2_output), .a20_line_gate(a20_line_gate),
        .processor_reset_out(processor_reset_out), .nmi_out(nmi_out),
        .speaker_out(speaker_out), .timer2_gate(timer2_gate),
        .expansion_bus_clock(expansion_bus_clock), .io_recovery_clocks(io_recovery_clocks),
        .slow_refresh_en(slow_refresh_en), .hidden_refresh_en(hidden_refresh_en),
        .byte_swap_en(byte_swap_en), .ale_per_cycle(ale_per_cycle),
        .extra_wait_en(extra_wait_en), .parity_check_en(parity_check_en));
    atscr_host u_atscr_host (.core_clk(core_clk), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_rd_claim(io_rd_claim));
    always #4 core_clk = ~core_clk;
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chki(input string s, input int e, input int g);
        n_tests++;
        if (g != e) begin
            mismatches++;
            $display("[ERR] %s expected %0d seen %0d", s, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // Pulse kinds: 0 refresh, 1 parity, 2 halt, 3 channel pin low
    task automatic pls(input int k);
        tick(1);
        case (k)
            0: refresh_pulse = 1'b1;
            1: parity_error = 1'b1;
            2: halt_cycle = 1'b1;
            default: channel_error_in_n = 1'b0;
        endcase
        tick(1);
        {refresh_pulse, parity_error, halt_cycle} = 3'h0;
        channel_error_in_n = 1'b1;
    endtask
    task automatic wt(input logic v);
        n = 0;
        while (expansion_bus_clock !== v && n < 40) begin
            tick(1);
            n++;
        end
        if (n >= 40) begin
            chki("bus_clock_wait", 0, n);
            complete_run();
        end
    endtask
    task automatic rd61(input logic [7:0] e);
        u_atscr_host.rd(PORT_SYS_STATUS, d, c);
        chk("port61", e, d);
    endtask
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        halt_cycle = 1'b0;
        refresh_pulse = 1'b0;
        parity_error = 1'b0;
        channel_error_in_n = 1'b1;
        timer2_output = 1'b0;
        mismatches = 0;
        n_tests = 0;
        repeat (20) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        tick(1);
        chk("reset_outs", 8'h0C, {4'h0, ale_per_cycle, parity_check_en, byte_swap_en, a20_line_gate});
        u_atscr_host.cfg_rd(IDX_REV_BUS_CFG, d, c);
        chk("rev_bus_cfg", {RBC_REVISION, 6'h00}, d);
        u_atscr_host.cfg_rd(IDX_SYS_CTRL_CFG, d, c);
        chk("sys_ctrl_cfg", 8'h40, d);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) begin
            cd = i[1:0];
            u_atscr_host.cfg_wr(IDX_REV_BUS_CFG, {2'h3, cd, cd, cd});
            tick(12);
            u_atscr_host.cfg_rd(IDX_REV_BUS_CFG, d, c);
            chk("rev_bus_cfg", {RBC_REVISION, cd, cd, cd}, d);
            chk("recovery", 8'h03 + {6'h00, cd}, {5'h00, io_recovery_clocks});
            chk("refresh_modes", {6'h00, cd}, {6'h00, slow_refresh_en, hidden_refresh_en});
            wt(1'b0);
            wt(1'b1);
            h = 0;
            while (expansion_bus_clock === 1'b1 && h < 40) begin
                tick(1);
                h++;
            end
            chki("half_period", 5 - i, h);
            if (h >= 40) begin
                complete_run();
            end
        end
        $display("test bus_config done");
        u_atscr_host.rd(PORT_CFG_DATA, d, c);
        chk("stale_index", 8'h00, {c, d[6:0]});
        u_atscr_host.rd(PORT_KBD_DATA, d, c);
        chk("kbd_no_status", 8'h00, {7'h00, c});
        $display("test refusals done");
        u_atscr_host.cfg_wr(IDX_SYS_CTRL_CFG, 8'hB1);
        tick(2);
        chk("sys_outs", 8'h0A, {4'h0, byte_swap_en, ale_per_cycle, extra_wait_en, parity_check_en});
        u_atscr_host.wr(PORT_KBD_CMD, CMD_FAST_RESET);
        tick(1);
        chk("direct_reset", 8'h01, {7'h00, processor_reset_out});
        h = 0;
        while (processor_reset_out === 1'b1 && h < 300) begin
            tick(1);
            h++;
        end
        chki("reset_len", RESET_PULSE_CYCLES - 1, h);
        if (h >= 300) begin
            complete_run();
        end
        u_atscr_host.cfg_wr(IDX_SYS_CTRL_CFG, 8'h00);
        u_atscr_host.wr(PORT_KBD_CMD, CMD_FAST_RESET);
        tick(4);
        chk("armed_reset", 8'h00, {7'h00, processor_reset_out});
        pls(2);
        tick(1);
        chk("halt_reset", 8'h01, {7'h00, processor_reset_out});
        tick(130);
        $display("test fast_reset done");
        u_atscr_host.wr(PORT_KBD_CMD, CMD_WRITE_OUTPUT);
        u_atscr_host.wr(PORT_KBD_DATA, DATA_A20_ON);
        chk("a20_on", 8'h01, {7'h00, a20_line_gate});
        u_atscr_host.wr(PORT_KBD_CMD, CMD_READ_STATUS);
        u_atscr_host.rd(PORT_KBD_DATA, d, c);
        chk("kbd_status", 8'h82, {c, d[6:0]});
        u_atscr_host.wr(PORT_KBD_CMD, CMD_WRITE_OUTPUT);
        u_atscr_host.wr(PORT_KBD_DATA, 8'h00);
        chk("a20_off", 8'h00, {7'h00, a20_line_gate});
        $display("test keyboard done");
        u_atscr_host.wr(PORT_SYS_STATUS, 8'h03);
        timer2_output = 1'b1;
        repeat (3) pls(0);
        tick(2);
        chk("gate_speaker", 8'h03, {6'h00, timer2_gate, speaker_out});
        rd61(8'h33);
        u_atscr_host.wr(PORT_SYS_STATUS, 8'h01);
        tick(3);
        chk("speaker_off", 8'h00, {7'h00, speaker_out});
        pls(1);
        tick(3);
        chk("nmi_parity", 8'h01, {7'h00, nmi_out});
        rd61(8'hB1);
        u_atscr_host.wr(PORT_SYS_STATUS, 8'h05);
        pls(1);
        tick(3);
        chk("nmi_masked", 8'h00, {7'h00, nmi_out});
        rd61(8'h35);
        u_atscr_host.wr(PORT_SYS_STATUS, 8'h01);
        pls(3);
        tick(6);
        chk("nmi_channel", 8'h01, {7'h00, nmi_out});
        rd61(8'h71);
        u_atscr_host.wr(PORT_SYS_STATUS, 8'h09);
        pls(3);
        tick(6);
        chk("nmi_ch_masked", 8'h00, {7'h00, nmi_out});
        rd61(8'h39);
        $display("test port61 done");
        complete_run();
    end
endmodule
`default_nettype wire
